// >>> testbench/e1_backplane_model.sv
`timescale 1ns/1ns
// ====================================================================
// Backplane side: primary clock, serial data, signaling and natbit pins
module e1_backplane_model #(
    parameter int HALF = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic run,
    // Pins
    output logic tx_primary_clock,
    output logic tx_backplane_clock,
    output logic tx_backplane_sync,
    output logic tx_serial_in,
    output logic tx_signaling_in,
    output logic tx_natbit_in
);
    int cnt;
    // Store unused, so its clock and sync stay low
    assign tx_backplane_clock = 1'b0;
    assign tx_backplane_sync = 1'b0;
    assign tx_signaling_in = tx_serial_in;
    assign tx_natbit_in = ~tx_serial_in;
    // Whole-cycle phases trade the exact rate for repeatable counts
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            tx_primary_clock <= 1'b0;
            tx_serial_in <= 1'b0;
        end else if (!run) begin
            cnt <= 0;
            tx_primary_clock <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            tx_primary_clock <= ~tx_primary_clock;
            // Data moves on the rising edge, stable at the falling one
            if (!tx_primary_clock) begin
                tx_serial_in <= ~tx_serial_in;
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : e1_backplane_model

// >>> testbench/e1_transmit_system_interface_test.sv
`timescale 1ns/1ns
module e1_transmit_system_interface_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic run = 1'b0;
    logic rec_clk = 1'b0;
    logic [31:0] reg_rdata, d;
    logic pclk, bclk, bsync, ser, sig, nat, dem, sclk, sblk, fso, fsoe, sto;
    logic pos, neg, fclk, lost, lpos, lneg;
    wire [7:0] mon = {pos, dem, lpos, fclk, neg, fso, sblk, sclk};
    int mismatches = 0;
    int checks = 0;
    int n;
    e1_backplane_model bp_u (.clock(clock), .rstn(rstn), .run(run), .tx_primary_clock(pclk),
        .tx_backplane_clock(bclk), .tx_backplane_sync(bsync), .tx_serial_in(ser),
        .tx_signaling_in(sig), .tx_natbit_in(nat));
    e1_transmit_system_interface dut_u (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_primary_clock(pclk), .tx_backplane_clock(bclk),
        .tx_serial_in(ser), .tx_signaling_in(sig), .tx_backplane_sync(bsync),
        .tx_natbit_in(nat), .tx_natbit_demand_clock(dem), .tx_slot_clock(sclk),
        .tx_slot_block(sblk), .tx_frame_sync_in(1'b0), .tx_frame_sync_out(fso),
        .tx_frame_sync_oe(fsoe), .tx_store_out(sto), .tx_data_in(sto),
        .tx_pos_formatter_out(pos), .tx_neg_formatter_out(neg), .tx_formatter_clock_out(fclk),
        .recovered_clock_out(rec_clk), .rx_line_clock_in(1'b1),
        .lost_tx_clock_substitute(lost), .line_if_connect(1'b0), .line_clock_in(rec_clk),
        .line_pos_in(1'b1), .line_neg_in(1'b0), .line_pos_out(lpos), .line_neg_out(lneg));
    // ================================================================
    // Clocks
    initial begin
        forever #20 clock = ~clock;
    end
    always begin
        repeat (6) @(posedge clock);
        rec_clk <= ~rec_clk;
    end
    // ================================================================
    // Tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        chk(nm, e, d & m);
    endtask : rchk
    // Counts cycles with the monitored output high over a window
    task automatic hi(input string nm, input int s, input int len, input int e);
        n = 0;
        repeat (len) begin
            @(posedge clock);
            #1 if (mon[s] === 1'b1) n++;
        end
        chk(nm, 32'(e), 32'(n));
    endtask : hi
    // ================================================================
    // Tests
    initial begin
        repeat (20) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        rchk("control", e1_tx_pkg::OFS_TX_CONTROL_ONE, 32'h0);
        rchk("natsel", e1_tx_pkg::OFS_NATBIT_SELECT, 32'h0);
        rchk("blockmap", e1_tx_pkg::OFS_SLOT_BLOCK_MAP, 32'h0);
        wr(e1_tx_pkg::OFS_TX_CONTROL_ONE, 32'h01);
        wr(e1_tx_pkg::OFS_NATBIT_SELECT, 32'h1F);
        wr(e1_tx_pkg::OFS_SLOT_BLOCK_MAP, 32'h8000_0001);
        wr(8'h10, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h10, 32'h0);
        rchk("natsel", e1_tx_pkg::OFS_NATBIT_SELECT, 32'h1F);
        $display("test registers done");
        run <= 1'b1;
        repeat (200) @(posedge clock);
        hi("slot clock", 0, 3072, 384);
        hi("slot block", 1, 3072, 192);
        chk("sync oe", 32'h1, 32'(fsoe));
        hi("sync out", 2, 3072, 12);
        hi("demand", 6, 6144, 60);
        hi("formatter clock", 4, 3072, 1536);
        hi("line pos", 5, 240, 240);
        wr(e1_tx_pkg::OFS_TX_CONTROL_ONE, 32'h81);
        // A mark already on the rail stands until the next formatter edge
        repeat (24) @(posedge clock);
        hi("nrz neg", 3, 3072, 0);
        hi("nrz pos", 7, 3072, 1536);
        $display("test framing done");
        wr(e1_tx_pkg::OFS_TX_CONTROL_ONE, 32'h08);
        run <= 1'b0;
        repeat (100) @(posedge clock);
        chk("substitute", 32'h1, 32'(lost));
        rchk("status", e1_tx_pkg::OFS_STATUS, 32'h3, 32'h3);
        hi("recovered clock", 4, 1200, 600);
        wr(e1_tx_pkg::OFS_TX_CONTROL_ONE, 32'h10);
        hi("loopback clock", 4, 100, 100);
        $display("test substitution done");
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        close_out();
    end
endmodule : e1_transmit_system_interface_test

// >>> verilog/e1_transmit_system_interface.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
// Summary of operation
// [R1] Outside source supplies the primary transmit clock; its loss is watched here.
// [R2] Formatter clock follows primary, recovered clock under substitution, or loopback clock.
// [R3] Serial data sampled on falling primary clock, or backplane clock with store on.
// [R4] Slot clock goes high during the last bit of every channel.
// [R5] Slot clock and block follow primary clock, or backplane clock with store on.
// [R6] Slot block output is programmable high or low for each of 32 channels.
// [R7] Backplane clock runs only with the store on and is held low otherwise.
// [R8] Demand clock marks the selected national bits, giving 4 to 20 kHz in 4 kHz steps.
// [R9] National bit input sampled on falling primary clock into selected Sa4 to Sa8.
// [R10] Pulse on the frame sync pin sets the frame or multiframe boundary.
// [R11] As an output the frame sync pin drives a frame or multiframe pulse.
// [R12] Backplane sync pulse sets boundaries with the store on; held low otherwise.
// [R13] Signaling input sampled on the governing falling edge and inserted in slot 16.
// [R14] Store output updates on rising primary clock, store enabled or not.
// [R15] Formatter data input sampled on falling primary clock and formatted.
// [R16] Positive and negative formatter outputs update on formatter clock rising edges.
// [R17] Control bit 7 turns the positive output to NRZ data.
// [R18] Line interface samples its data on falling edges of its own clock.
// [R19] Connect pin routes formatter clock and data to the line interface.
// [R20] Slot clock stays high exactly one bit period, on the last bit.
module e1_transmit_system_interface (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Backplane
    input wire logic tx_primary_clock,
    input wire logic tx_backplane_clock,
    input wire logic tx_serial_in,
    input wire logic tx_signaling_in,
    input wire logic tx_backplane_sync,
    input wire logic tx_natbit_in,
    output logic tx_natbit_demand_clock,
    output logic tx_slot_clock,
    output logic tx_slot_block,
    // Frame sync pin
    input wire logic tx_frame_sync_in,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe,
    // Elastic store and formatter
    output logic tx_store_out,
    input wire logic tx_data_in,
    output logic tx_pos_formatter_out,
    output logic tx_neg_formatter_out,
    output logic tx_formatter_clock_out,
    // Clock substitution
    input wire logic recovered_clock_out,
    input wire logic rx_line_clock_in,
    output logic lost_tx_clock_substitute,
    // Line interface
    input wire logic line_if_connect,
    input wire logic line_clock_in,
    input wire logic line_pos_in,
    input wire logic line_neg_in,
    output logic line_pos_out,
    output logic line_neg_out
);
    e1_tx_pkg::tx_state_t st_r;
    e1_tx_pkg::tx_state_t st_nxt;
    e1_tx_pkg::slot_pos_t pos_a;
    e1_tx_pkg::slot_pos_t pos_b;
    logic [e1_tx_pkg::PIN_COUNT-1:0] pins;
    logic [e1_tx_pkg::PIN_COUNT-1:0] lvl;
    logic [e1_tx_pkg::PIN_COUNT-1:0] rise;
    logic [e1_tx_pkg::PIN_COUNT-1:0] fall;
    logic prim_fall;
    logic prim_rise;
    logic gov_fall;
    logic gov_restart;
    logic fsync_restart;
    logic lost_tx_clock_substitute_active;
    logic fmt_rise;
    logic line_fall;
    logic connect;
    logic sa_slot;
    logic sa_sel;
    logic ins_bit;
    logic fmt_bit;
    logic [2:0] sa_idx;
    logic [7:0] sa_vec;

    // ================================================================
    // Pin synchronisers
    // Every pin, clocks included, sees the same latency so data stays aligned to its clock
    assign pins = {line_if_connect, line_neg_in, line_pos_in, line_clock_in, rx_line_clock_in,
                   recovered_clock_out, tx_data_in, tx_frame_sync_in, tx_natbit_in,
                   tx_backplane_sync, tx_signaling_in, tx_serial_in, tx_backplane_clock,
                   tx_primary_clock};

    for (genvar i = 0; i < e1_tx_pkg::PIN_COUNT; i++) begin : g_sync
        pin_sync u_sync (
            .clock(clock),
            .rstn(rstn),
            .pin(pins[i]),
            .level(lvl[i]),
            .rise(rise[i]),
            .fall(fall[i])
        );
    end

    // ================================================================
    // Timing selection
    assign prim_fall = fall[e1_tx_pkg::PIN_PRIM_CLK];
    assign prim_rise = rise[e1_tx_pkg::PIN_PRIM_CLK];
    assign gov_fall = st_r.ctrl.store_en ? fall[e1_tx_pkg::PIN_BP_CLK] : prim_fall; // see [R5]
    // Sync in input mode only; an output pulse must not restart its own counter
    assign fsync_restart = !st_r.ctrl.sync_out && lvl[e1_tx_pkg::PIN_FSYNC]; // see [R10]
    assign gov_restart = st_r.ctrl.store_en ? lvl[e1_tx_pkg::PIN_BP_SYNC] : fsync_restart; // see [R12]
    assign lost_tx_clock_substitute_active = st_r.ctrl.lost_tx_clock_substitute_en && st_r.clk_lost;
    assign fmt_rise = st_r.fmt_clk && !st_r.fmt_clk_d;
    assign connect = lvl[e1_tx_pkg::PIN_CONNECT];
    // Internal route uses the formatter clock directly, so no synchroniser delay
    assign line_fall = connect ? (st_r.fmt_clk_d && !st_r.fmt_clk) : fall[e1_tx_pkg::PIN_LINE_CLK]; // see [R19]

    // Formatter position on the primary clock
    slot_counter u_fmt_pos (
        .clock(clock),
        .rstn(rstn),
        .step(prim_fall),
        .restart(fsync_restart),
        .restart_frame(st_r.ctrl.sync_mf),
        .pos(pos_a)
    );

    // Backplane position on the governing clock
    slot_counter u_bp_pos (
        .clock(clock),
        .rstn(rstn),
        .step(gov_fall),
        .restart(gov_restart),
        .restart_frame(st_r.ctrl.sync_mf),
        .pos(pos_b)
    );

    // ================================================================
    // Data path selection
    assign sa_idx = 3'(pos_a.bitn - e1_tx_pkg::SA_FIRST_BIT);
    assign sa_vec = {3'h0, st_r.natsel};
    // Sa bits live in channel 0 of frames without the alignment word
    assign sa_slot = pos_a.frame[0] && (pos_a.chan == e1_tx_pkg::NATBIT_SLOT)
                     && (pos_a.bitn >= e1_tx_pkg::SA_FIRST_BIT);
    assign sa_sel = sa_slot && sa_vec[sa_idx];
    assign ins_bit = (st_r.ctrl.sig_en && pos_b.chan == e1_tx_pkg::CAS_SLOT) ? st_r.sig : st_r.ser; // see [R13]
    assign fmt_bit = (st_r.ctrl.natbit_en && sa_sel) ? st_r.nat : st_r.data; // see [R9]

    // ================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;

        // Register port
        if (reg_write) begin
            unique case (reg_addr)
                e1_tx_pkg::OFS_TX_CONTROL_ONE: st_nxt.ctrl = e1_tx_pkg::ctrl_t'(reg_wdata[7:0]);
                e1_tx_pkg::OFS_NATBIT_SELECT: st_nxt.natsel = reg_wdata[4:0];
                e1_tx_pkg::OFS_SLOT_BLOCK_MAP: st_nxt.block_map = reg_wdata;
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                e1_tx_pkg::OFS_TX_CONTROL_ONE: st_nxt.rdata = {24'h000000, st_r.ctrl};
                e1_tx_pkg::OFS_NATBIT_SELECT: st_nxt.rdata = {27'h0000000, st_r.natsel};
                e1_tx_pkg::OFS_SLOT_BLOCK_MAP: st_nxt.rdata = st_r.block_map;
                e1_tx_pkg::OFS_STATUS: st_nxt.rdata = {12'h000, pos_a.frame, 3'h0, pos_a.chan,
                                                       6'h00, lost_tx_clock_substitute_active, st_r.clk_lost};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Primary clock watchdog: no edge for the limit means the source is gone
        if (prim_rise || prim_fall) begin // see [R1]
            st_nxt.idle_cnt = 6'h00;
            st_nxt.clk_lost = 1'b0;
        end else if (st_r.idle_cnt == e1_tx_pkg::LOST_TX_CLOCK_SUBSTITUTE_CYCLES) begin
            st_nxt.clk_lost = 1'b1;
        end else begin
            st_nxt.idle_cnt = 6'(st_r.idle_cnt + 6'h01);
        end

        // Formatter clock source
        if (st_r.ctrl.remote_lb) begin // see [R2]
            st_nxt.fmt_clk = lvl[e1_tx_pkg::PIN_RX_LINE_CLK];
        end else if (lost_tx_clock_substitute_active) begin
            st_nxt.fmt_clk = lvl[e1_tx_pkg::PIN_REC_CLK];
        end else begin
            st_nxt.fmt_clk = lvl[e1_tx_pkg::PIN_PRIM_CLK];
        end
        st_nxt.fmt_clk_d = st_r.fmt_clk;

        // Backplane sampling on the governing falling edge
        if (gov_fall) begin // see [R3]
            st_nxt.ser = lvl[e1_tx_pkg::PIN_SER];
            if (st_r.ctrl.sig_en) begin // see [R13]
                st_nxt.sig = lvl[e1_tx_pkg::PIN_SIG];
            end
        end

        // Elastic store: written on rising backplane clock edges, read on the primary clock.
        // No slip detection; the pointers restart half a store apart when it is off.
        if (!st_r.ctrl.store_en) begin
            st_nxt.es_wr = e1_tx_pkg::ES_START_GAP;
            st_nxt.es_rd = 4'h0;
        end else if (rise[e1_tx_pkg::PIN_BP_CLK]) begin
            st_nxt.es_mem[st_r.es_wr] = ins_bit;
            st_nxt.es_wr = 4'(st_r.es_wr + 4'h1);
        end
        if (prim_rise) begin // see [R14]
            if (st_r.ctrl.store_en) begin
                st_nxt.store_out = st_r.es_mem[st_r.es_rd];
                st_nxt.es_rd = 4'(st_r.es_rd + 4'h1);
            end else begin
                st_nxt.store_out = ins_bit;
            end
        end

        // Formatter input sampling on the primary falling edge
        if (prim_fall) begin // see [R15]
            st_nxt.data = lvl[e1_tx_pkg::PIN_TDATA];
            if (st_r.ctrl.natbit_en) begin // see [R9]
                st_nxt.nat = lvl[e1_tx_pkg::PIN_NATBIT];
            end
        end
        st_nxt.demand = sa_sel; // see [R8]

        // Channel timing outputs; slot clock and sync pulse one bit period wide, slot block per channel
        st_nxt.slot_clk = (pos_b.bitn == e1_tx_pkg::SLOT_LSB_BIT); // see [R4] see [R20]
        st_nxt.slot_blk = st_r.block_map[pos_b.chan]; // see [R6]
        st_nxt.sync_pulse = st_r.ctrl.sync_out && (pos_a.chan == 5'h00)
                            && (pos_a.bitn == e1_tx_pkg::FIRST_BIT)
                            && (!st_r.ctrl.sync_mf || pos_a.frame == e1_tx_pkg::FIRST_FRAME); // see [R11]

        // Bipolar encoder; marks alternate polarity, spaces drive neither rail
        if (fmt_rise) begin // see [R16]
            if (st_r.ctrl.nrz) begin // see [R17]
                st_nxt.pos_out = fmt_bit;
                st_nxt.neg_out = 1'b0;
            end else if (fmt_bit) begin
                st_nxt.pos_out = !st_r.ami_pol;
                st_nxt.neg_out = st_r.ami_pol;
                st_nxt.ami_pol = !st_r.ami_pol;
            end else begin
                st_nxt.pos_out = 1'b0;
                st_nxt.neg_out = 1'b0;
            end
        end

        // Line interface input stage
        if (line_fall) begin // see [R18]
            st_nxt.line_pos = connect ? st_r.pos_out : lvl[e1_tx_pkg::PIN_LINE_POS]; // see [R19]
            st_nxt.line_neg = connect ? st_r.neg_out : lvl[e1_tx_pkg::PIN_LINE_NEG];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.ctrl <= e1_tx_pkg::ctrl_t'(e1_tx_pkg::CONTROL_RESET);
            st_r.natsel <= e1_tx_pkg::NATSEL_RESET;
            st_r.block_map <= e1_tx_pkg::BLOCK_MAP_RESET;
            st_r.es_wr <= e1_tx_pkg::ES_START_GAP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ================================================================
    // Outputs
    assign reg_rdata = st_r.rdata;
    assign tx_natbit_demand_clock = st_r.demand;
    assign tx_slot_clock = st_r.slot_clk;
    assign tx_slot_block = st_r.slot_blk;
    assign tx_frame_sync_out = st_r.sync_pulse;
    assign tx_frame_sync_oe = st_r.ctrl.sync_out;
    assign tx_store_out = st_r.store_out;
    assign tx_pos_formatter_out = st_r.pos_out;
    assign tx_neg_formatter_out = st_r.neg_out;
    assign tx_formatter_clock_out = st_r.fmt_clk;
    assign lost_tx_clock_substitute = lost_tx_clock_substitute_active;
    assign line_pos_out = st_r.line_pos;
    assign line_neg_out = st_r.line_neg;

    // ================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_fmt_edge;
        fmt_rise;
    endsequence
    sequence s_nrz_quiet;
        st_r.ctrl.nrz ##1 !tx_neg_formatter_out;
    endsequence

    property p_fmt_loopback;
        st_r.ctrl.remote_lb |=> tx_formatter_clock_out == $past(lvl[e1_tx_pkg::PIN_RX_LINE_CLK]);
    endproperty
    a_fmt_loopback: assert property (p_fmt_loopback) else $error("formatter clock not loopback"); // see [R2]

    property p_ser_sample;
        gov_fall |=> st_r.ser == $past(lvl[e1_tx_pkg::PIN_SER]);
    endproperty
    a_ser_sample: assert property (p_ser_sample) else $error("serial data not sampled"); // see [R3]

    property p_slot_lsb;
        $rose(tx_slot_clock) |-> pos_b.bitn == 3'h7 && $past(gov_fall, 2);
    endproperty
    a_slot_lsb: assert property (p_slot_lsb) else $error("slot clock off the last bit"); // see [R4]

    property p_slot_one_bit;
        $fell(tx_slot_clock) |-> $past(gov_fall, 2) && pos_b.bitn == 3'h0;
    endproperty
    a_slot_one_bit: assert property (p_slot_one_bit) else $error("slot clock width wrong"); // see [R20]

    property p_block_map;
        $changed(tx_slot_block) |-> tx_slot_block == st_r.block_map[$past(pos_b.chan)];
    endproperty
    a_block_map: assert property (p_block_map) else $error("slot block not from map"); // see [R6]

    property p_sync_out;
        tx_frame_sync_out |-> $past(tx_frame_sync_oe) && $past(pos_a.bitn) == 3'h0
                              && $past(pos_a.chan) == 5'h00;
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("sync pulse off frame start"); // see [R11]

    property p_store_edge;
        $changed(tx_store_out) |-> $past(prim_rise);
    endproperty
    a_store_edge: assert property (p_store_edge) else $error("store output moved off edge"); // see [R14]

    property p_fmt_edge;
        $changed({tx_pos_formatter_out, tx_neg_formatter_out}) |-> $past(fmt_rise);
    endproperty
    a_fmt_edge: assert property (p_fmt_edge) else $error("formatter output moved off edge"); // see [R16]

    property p_nrz;
        s_fmt_edge |-> s_nrz_quiet or !st_r.ctrl.nrz;
    endproperty
    a_nrz: assert property (p_nrz) else $error("negative rail active in NRZ mode"); // see [R17]

    property p_line_edge;
        $changed({line_pos_out, line_neg_out}) |-> $past(line_fall);
    endproperty
    a_line_edge: assert property (p_line_edge) else $error("line sample off falling edge"); // see [R18]

    property p_natbit;
        prim_fall && st_r.ctrl.natbit_en |=> st_r.nat == $past(lvl[e1_tx_pkg::PIN_NATBIT]);
    endproperty
    a_natbit: assert property (p_natbit) else $error("national bit not sampled"); // see [R9]
endmodule : e1_transmit_system_interface

// >>> verilog/e1_tx_pkg.sv
// ====================================================================
// Shared constants and types
package e1_tx_pkg;

    // ================================================================
    // Timing
    localparam int CLOCK_PERIOD_NS = 40;
    // Longest silence tolerated on the primary transmit clock
    localparam int LOST_TX_CLOCK_SUBSTITUTE_TIME_NS = 2000;
    // A longest time rounds down to whole cycles
    localparam logic [5:0] LOST_TX_CLOCK_SUBSTITUTE_CYCLES = 6'(LOST_TX_CLOCK_SUBSTITUTE_TIME_NS / CLOCK_PERIOD_NS);

    // ================================================================
    // Register offsets (byte addresses) and reset values
    localparam logic [7:0] OFS_TX_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_NATBIT_SELECT = 8'h04;
    localparam logic [7:0] OFS_SLOT_BLOCK_MAP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [4:0] NATSEL_RESET = 5'h00;
    localparam logic [31:0] BLOCK_MAP_RESET = 32'h0000_0000;

    // ================================================================
    // Frame structure
    localparam logic [2:0] SLOT_LSB_BIT = 3'h7;
    localparam logic [2:0] SA_FIRST_BIT = 3'h3;
    localparam logic [4:0] NATBIT_SLOT = 5'h00;
    localparam logic [4:0] CAS_SLOT = 5'h10;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [3:0] FIRST_FRAME = 4'h0;

    // ================================================================
    // Transmit elastic store
    localparam int ES_DEPTH = 16;
    localparam logic [3:0] ES_START_GAP = 4'h8;

    // ================================================================
    // Pin synchroniser slots
    localparam int PIN_COUNT = 14;
    localparam int PIN_PRIM_CLK = 0;
    localparam int PIN_BP_CLK = 1;
    localparam int PIN_SER = 2;
    localparam int PIN_SIG = 3;
    localparam int PIN_BP_SYNC = 4;
    localparam int PIN_NATBIT = 5;
    localparam int PIN_FSYNC = 6;
    localparam int PIN_TDATA = 7;
    localparam int PIN_REC_CLK = 8;
    localparam int PIN_RX_LINE_CLK = 9;
    localparam int PIN_LINE_CLK = 10;
    localparam int PIN_LINE_POS = 11;
    localparam int PIN_LINE_NEG = 12;
    localparam int PIN_CONNECT = 13;

    // ================================================================
    // Types
    typedef struct packed {
        logic [3:0] frame;
        logic [4:0] chan;
        logic [2:0] bitn;
    } slot_pos_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    // Bit 7 down to bit 0 of the first transmit control register
    typedef struct packed {
        logic nrz;
        logic sig_en;
        logic natbit_en;
        logic remote_lb;
        logic lost_tx_clock_substitute_en;
        logic store_en;
        logic sync_mf;
        logic sync_out;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [4:0] natsel;
        logic [31:0] block_map;
        logic [31:0] rdata;
        logic [5:0] idle_cnt;
        logic clk_lost;
        logic fmt_clk;
        logic fmt_clk_d;
        logic ser;
        logic sig;
        logic [ES_DEPTH-1:0] es_mem;
        logic [3:0] es_wr;
        logic [3:0] es_rd;
        logic store_out;
        logic data;
        logic nat;
        logic demand;
        logic slot_clk;
        logic slot_blk;
        logic sync_pulse;
        logic pos_out;
        logic neg_out;
        logic ami_pol;
        logic line_pos;
        logic line_neg;
    } tx_state_t;

endpackage : e1_tx_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/1ns
// ====================================================================
// Three-stage pin synchroniser with filtered level and edge pulses
module pin_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pin
    input wire logic pin,
    // Filtered result
    output logic level,
    output logic rise,
    output logic fall
);
    e1_tx_pkg::sync_state_t state_r;
    e1_tx_pkg::sync_state_t state_nxt;
    logic agree;

    // Stage one feeds only stage two; the level moves once two and three agree
    assign agree = (state_r.s2 == state_r.s3);
    assign level = state_r.level;
    assign rise = agree && state_r.s3 && !state_r.level;
    assign fall = agree && !state_r.s3 && state_r.level;

    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = pin;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        if (agree) begin
            state_nxt.level = state_r.s3;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : pin_sync

// >>> verilog/slot_counter.sv
`timescale 1ns/1ns
// ====================================================================
// Bit, channel and frame position within a sixteen-frame multiframe
module slot_counter (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Timing
    input wire logic step,
    input wire logic restart,
    input wire logic restart_frame,
    // Position of the bit sampled at the last step
    output e1_tx_pkg::slot_pos_t pos
);
    e1_tx_pkg::slot_pos_t state_r;
    e1_tx_pkg::slot_pos_t state_nxt;

    assign pos = state_r;

    always_comb begin
        state_nxt = state_r;
        if (step && restart) begin
            // A sync pulse marks the first bit of a frame or multiframe
            state_nxt.bitn = e1_tx_pkg::FIRST_BIT;
            state_nxt.chan = 5'h00;
            state_nxt.frame = restart_frame ? e1_tx_pkg::FIRST_FRAME : 4'(state_r.frame + 4'h1);
        end else if (step) begin
            // Packed fields carry into each other and wrap at the multiframe
            state_nxt = e1_tx_pkg::slot_pos_t'(12'(state_r + 12'h001));
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : slot_counter
